// [inc/isr_cfg.svh]
`ifndef ISR_CFG_SVH
`define ISR_CFG_SVH
// Summary byte bit positions.
`define ISR_SB_QUEST 3
`define ISR_SB_REPLY 4
`define ISR_SB_STD 5
`define ISR_SB_MASTER 6
`define ISR_SB_OP 7
// Standard event bit positions.
`define ISR_SE_DONE 0
`define ISR_SE_QUERY 2
`define ISR_SE_DEVICE 3
`define ISR_SE_RUN 4
`define ISR_SE_SYNTAX 5
`define ISR_SE_POWERUP 7
// Operation register bit positions.
`define ISR_OP_PROBE_ABSENT 0
`define ISR_OP_OVERRANGE 1
`define ISR_OP_RANGING 2
`define ISR_OP_RAMP_DONE 5
`define ISR_OP_NO_CAL 6
// Used bits of the operation and questionable registers.
`define ISR_OP_USED 8'h0067
`define ISR_QU_USED 16'h03ff
// Error code range limits, as magnitudes of the negative codes.
`define ISR_SYN_LO 10'h0064
`define ISR_SYN_HI 10'h00b8
`define ISR_RUN_LO 10'h00c8
`define ISR_RUN_HI 10'h0126
`define ISR_DEV_LO 10'h012c
`define ISR_DEV_HI 10'h016d
`define ISR_QRY_LO 10'h0190
`define ISR_QRY_HI 10'h01b8
// Error queue geometry.
`define ISR_EQ_DEPTH 8
`define ISR_EQ_AW 3
`define ISR_EQ_CW 4
`define ISR_EQ_WIDTH 16
`define ISR_ONE_CW 4'h1
`define ISR_ZERO_CW 4'h0
`define ISR_ZERO8 8'h00
`define ISR_ZERO16 16'h0000
`endif

// [inc/isr_pkg.sv]
`default_nettype none
`include "isr_cfg.svh"
package isr_pkg;
  // Host command codes.
  typedef enum logic [3:0] {
    ISR_CMD_NONE = 4'h0,
    ISR_CMD_RD_SUMMARY = 4'h1,
    ISR_CMD_WR_SRQ_MASK = 4'h2,
    ISR_CMD_RD_SRQ_MASK = 4'h3,
    ISR_CMD_RD_STD_EVENT = 4'h4,
    ISR_CMD_WR_STD_MASK = 4'h5,
    ISR_CMD_RD_STD_MASK = 4'h6,
    ISR_CMD_RD_OP_EVENT = 4'h7,
    ISR_CMD_RD_OP_COND = 4'h8,
    ISR_CMD_WR_OP_MASK = 4'h9,
    ISR_CMD_RD_OP_MASK = 4'ha,
    ISR_CMD_RD_QU_EVENT = 4'hb,
    ISR_CMD_RD_QU_COND = 4'hc,
    ISR_CMD_WR_QU_MASK = 4'hd,
    ISR_CMD_RD_QU_MASK = 4'he,
    ISR_CMD_CLEAR_STATUS = 4'hf
  } isr_cmd_type;

  // Error queue operations.
  typedef enum logic [2:0] {
    ISR_EQ_NONE = 3'h0,
    ISR_EQ_NEXT = 3'h1,
    ISR_EQ_ALL = 3'h2,
    ISR_EQ_CLEAR = 3'h3,
    ISR_EQ_COUNT = 3'h4
  } isr_eq_op_type;

  typedef struct packed {
    isr_cmd_type cmd;
    logic [15:0] data;
  } isr_req_type;

  typedef struct packed {
    logic valid;
    logic [15:0] data;
  } isr_resp_type;
endpackage : isr_pkg
`default_nettype wire

// [verilog/isr_err_range.sv]
`default_nettype none
`include "isr_cfg.svh"
// Maps the magnitude of a negative error code to the standard event bit.
module isr_err_range (
  // Code
  input wire logic [9:0] code_mag,
  // Event bits to set
  output logic [7:0] std_bits
);
  function automatic logic in_range(input logic [9:0] v, input logic [9:0] lo,
                                    input logic [9:0] hi);
    in_range = (v >= lo) && (v <= hi);
  endfunction : in_range

  wire logic syn_hit = in_range(code_mag, `ISR_SYN_LO, `ISR_SYN_HI);
  wire logic run_hit = in_range(code_mag, `ISR_RUN_LO, `ISR_RUN_HI);
  wire logic dev_hit = in_range(code_mag, `ISR_DEV_LO, `ISR_DEV_HI);
  wire logic qry_hit = in_range(code_mag, `ISR_QRY_LO, `ISR_QRY_HI);

  always_comb
  begin
    std_bits = `ISR_ZERO8;
    std_bits[`ISR_SE_SYNTAX] = syn_hit;
    std_bits[`ISR_SE_RUN] = run_hit;
    std_bits[`ISR_SE_DEVICE] = dev_hit;
    std_bits[`ISR_SE_QUERY] = qry_hit;
  end
endmodule : isr_err_range
`default_nettype wire

// [verilog/isr_err_queue.sv]
`default_nettype none
`include "isr_cfg.svh"
// First-in first-out store of coded error messages.
module isr_err_queue (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Push side
  input wire logic push,
  input wire logic [15:0] push_code,
  // Pop and clear
  input wire logic pop,
  input wire logic clear,
  // State
  output logic [15:0] head,
  output logic [3:0] count,
  output logic empty,
  output logic full
);
  logic [15:0] mem_q [`ISR_EQ_DEPTH];
  logic [2:0] rd_q;
  logic [2:0] wr_q;
  logic [3:0] cnt_q;

  wire logic do_pop = pop && !empty;
  // A full queue drops the newest entry; the oldest ones are kept.
  wire logic do_push = push && (!full || do_pop);

  assign empty = (cnt_q == `ISR_ZERO_CW);
  assign full = (cnt_q == 4'(`ISR_EQ_DEPTH));
  assign count = cnt_q;
  assign head = empty ? `ISR_ZERO16 : mem_q[rd_q];

  always_ff @(posedge clk)
  begin
    if (do_push && !clear)
    begin
      mem_q[wr_q] <= push_code;
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rd_q <= 3'h0;
      wr_q <= 3'h0;
      cnt_q <= `ISR_ZERO_CW;
    end
    else if (clear)
    begin
      rd_q <= 3'h0;
      wr_q <= 3'h0;
      cnt_q <= `ISR_ZERO_CW;
    end
    else
    begin
      if (do_pop)
      begin
        rd_q <= rd_q + 3'h1;
      end
      if (do_push)
      begin
        wr_q <= wr_q + 3'h1;
      end
      cnt_q <= cnt_q + (do_push ? `ISR_ONE_CW : `ISR_ZERO_CW)
        - (do_pop ? `ISR_ONE_CW : `ISR_ZERO_CW);
    end
  end
endmodule : isr_err_queue
`default_nettype wire

// [verilog/isr_status.sv]
`default_nettype none
`include "isr_cfg.svh"
////////////////////////////////////////////////////////////////////////////
////////////////////////////////////////////////////////////////////////////
module isr_status (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Host commands and answers
  input wire isr_pkg::isr_req_type req,
  output isr_pkg::isr_resp_type resp,
  // Error queue commands
  input wire isr_pkg::isr_eq_op_type eq_op,
  output logic [15:0] eq_data,
  output logic eq_valid,
  output logic eq_more,
  // Error reports from the interpreter, two's complement codes
  input wire logic err_push,
  input wire logic [15:0] err_code,
  // Output buffer state and events
  input wire logic out_buf_nonempty,
  input wire logic reply_lost,
  input wire logic done_cmd,
  input wire logic ops_pending,
  // Instrument conditions
  input wire logic [7:0] op_cond,
  input wire logic [15:0] quest_cond,
  // Status
  output logic [7:0] summary_byte,
  output logic master_request,
  output logic err_available
);
  logic [7:0] std_event_q;
  logic [7:0] std_mask_q;
  logic [7:0] op_event_q;
  logic [7:0] op_mask_q;
  logic [15:0] quest_event_q;
  logic [15:0] quest_mask_q;
  logic [7:0] srq_mask_q;
  logic [7:0] op_prev_q;
  logic [15:0] quest_prev_q;
  logic done_armed_q;
  logic pwr_pend_q;
  isr_pkg::isr_resp_type resp_q;
  logic [15:0] eq_data_q;
  logic eq_valid_q;
  logic all_mode_q;

  function automatic logic any_en(input logic [15:0] ev,
                                  input logic [15:0] en);
    any_en = |(ev & en);
  endfunction : any_en

  ////////////////////////////////////////////////////////////////////////
  // Command decode.
  wire isr_pkg::isr_cmd_type cmd = req.cmd;
  wire logic rd_std = (cmd == isr_pkg::ISR_CMD_RD_STD_EVENT);
  wire logic rd_op = (cmd == isr_pkg::ISR_CMD_RD_OP_EVENT);
  wire logic rd_qu = (cmd == isr_pkg::ISR_CMD_RD_QU_EVENT);
  wire logic cls = (cmd == isr_pkg::ISR_CMD_CLEAR_STATUS);
  wire logic wr_srq = (cmd == isr_pkg::ISR_CMD_WR_SRQ_MASK);
  wire logic wr_std = (cmd == isr_pkg::ISR_CMD_WR_STD_MASK);
  wire logic wr_op = (cmd == isr_pkg::ISR_CMD_WR_OP_MASK);
  wire logic wr_qu = (cmd == isr_pkg::ISR_CMD_WR_QU_MASK);

  ////////////////////////////////////////////////////////////////////////
  // Error queue and code ranges.
  wire logic is_negative = err_code[15];
  wire logic [15:0] mag16 = 16'h0000 - err_code;
  wire logic mag_fits = (mag16[15:10] == 6'h00);
  wire logic [7:0] range_bits;
  // Positive codes are refused outright; only negative codes of magnitude below 1024 are stored.
  wire logic q_push = err_push && is_negative && mag_fits;
  wire logic [15:0] q_head;
  wire logic [3:0] q_count;
  wire logic q_empty;
  wire logic q_pop = (eq_op == isr_pkg::ISR_EQ_NEXT) ||
                     (eq_op == isr_pkg::ISR_EQ_ALL) ||
                     all_mode_q;
  wire logic q_clear = (eq_op == isr_pkg::ISR_EQ_CLEAR) || cls;

  isr_err_range u_range (
    .code_mag(mag16[9:0]),
    .std_bits(range_bits)
  );

  isr_err_queue u_queue (
    .clk(clk),
    .nrst(nrst),
    .push(q_push),
    .push_code(err_code),
    .pop(q_pop),
    .clear(q_clear),
    .head(q_head),
    .count(q_count),
    .empty(q_empty),
    .full()
  );

  ////////////////////////////////////////////////////////////////////////
  // Event sources.
  wire logic done_fire = (done_armed_q || done_cmd) && !ops_pending;
  wire logic [7:0] op_rise = op_cond & ~op_prev_q & `ISR_OP_USED;
  wire logic [15:0] quest_rise =
    quest_cond & ~quest_prev_q & `ISR_QU_USED;
  wire logic [7:0] std_set = (q_push ? range_bits : `ISR_ZERO8)
    | ({7'h00, done_fire} << `ISR_SE_DONE)
    | ({7'h00, reply_lost} << `ISR_SE_QUERY)
    | ({7'h00, pwr_pend_q} << `ISR_SE_POWERUP);

  // Set wins over a clear in the same cycle so no event is lost.
  wire logic [7:0] std_event_d = ((rd_std || cls) ? `ISR_ZERO8 : std_event_q)
    | std_set;
  wire logic [7:0] op_event_d = ((rd_op || cls) ? `ISR_ZERO8 : op_event_q)
    | op_rise;
  wire logic [15:0] quest_event_d =
    ((rd_qu || cls) ? `ISR_ZERO16 : quest_event_q) | quest_rise;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      std_event_q <= `ISR_ZERO8;
      op_event_q <= `ISR_ZERO8;
      quest_event_q <= `ISR_ZERO16;
      std_mask_q <= `ISR_ZERO8;
      op_mask_q <= `ISR_ZERO8;
      quest_mask_q <= `ISR_ZERO16;
      srq_mask_q <= `ISR_ZERO8;
      op_prev_q <= `ISR_ZERO8;
      quest_prev_q <= `ISR_ZERO16;
      done_armed_q <= 1'b0;
      pwr_pend_q <= 1'b1;
    end
    else
    begin
      std_event_q <= std_event_d;
      op_event_q <= op_event_d;
      quest_event_q <= quest_event_d;
      op_prev_q <= op_cond;
      quest_prev_q <= quest_cond;
      pwr_pend_q <= 1'b0;
      done_armed_q <= (done_armed_q || done_cmd) && ops_pending;
      if (wr_srq)
      begin
        srq_mask_q <= req.data[7:0];
      end
      if (wr_std)
      begin
        std_mask_q <= req.data[7:0];
      end
      if (wr_op)
      begin
        op_mask_q <= req.data[7:0];
      end
      if (wr_qu)
      begin
        quest_mask_q <= req.data;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Summary byte, purely combinational.
  wire logic op_summary =
    any_en({8'h00, op_event_q}, {8'h00, op_mask_q});
  wire logic std_summary =
    any_en({8'h00, std_event_q}, {8'h00, std_mask_q});
  wire logic quest_summary = any_en(quest_event_q, quest_mask_q);
  wire logic reply_pending = out_buf_nonempty;
  logic [7:0] sum_raw;

  always_comb
  begin
    sum_raw = `ISR_ZERO8;
    sum_raw[`ISR_SB_OP] = op_summary;
    sum_raw[`ISR_SB_STD] = std_summary;
    sum_raw[`ISR_SB_REPLY] = reply_pending;
    sum_raw[`ISR_SB_QUEST] = quest_summary;
  end

  assign master_request = any_en({8'h00, sum_raw}, {8'h00, srq_mask_q});
  assign summary_byte = sum_raw | ({7'h00, master_request} << `ISR_SB_MASTER);
  assign err_available = !q_empty;

  ////////////////////////////////////////////////////////////////////////
  // Query answers, registered one cycle after the command.
  logic [15:0] rd_mux;

  always_comb
  begin
    rd_mux = `ISR_ZERO16;
    case (cmd)
      isr_pkg::ISR_CMD_RD_SUMMARY: rd_mux = {8'h00, summary_byte};
      isr_pkg::ISR_CMD_RD_SRQ_MASK: rd_mux = {8'h00, srq_mask_q};
      isr_pkg::ISR_CMD_RD_STD_EVENT: rd_mux = {8'h00, std_event_q};
      isr_pkg::ISR_CMD_RD_STD_MASK: rd_mux = {8'h00, std_mask_q};
      isr_pkg::ISR_CMD_RD_OP_EVENT: rd_mux = {8'h00, op_event_q};
      isr_pkg::ISR_CMD_RD_OP_COND:
        rd_mux = {8'h00, op_cond & `ISR_OP_USED};
      isr_pkg::ISR_CMD_RD_OP_MASK: rd_mux = {8'h00, op_mask_q};
      isr_pkg::ISR_CMD_RD_QU_EVENT: rd_mux = quest_event_q;
      isr_pkg::ISR_CMD_RD_QU_COND:
        rd_mux = quest_cond & `ISR_QU_USED;
      isr_pkg::ISR_CMD_RD_QU_MASK: rd_mux = quest_mask_q;
      default: rd_mux = `ISR_ZERO16;
    endcase
  end

  wire logic is_read = (cmd != isr_pkg::ISR_CMD_NONE) && !cls &&
                       !wr_srq && !wr_std && !wr_op && !wr_qu;
  wire logic eq_answer = (eq_op == isr_pkg::ISR_EQ_NEXT) ||
                         (eq_op == isr_pkg::ISR_EQ_COUNT) ||
                         (eq_op == isr_pkg::ISR_EQ_ALL) || all_mode_q;
  wire logic [15:0] eq_word = (eq_op == isr_pkg::ISR_EQ_COUNT) ?
                              {12'h000, q_count} : q_head;
  // Read-all streams one entry per cycle until the queue runs dry.
  wire logic all_next = ((eq_op == isr_pkg::ISR_EQ_ALL) || all_mode_q) &&
                        (q_count > `ISR_ONE_CW) && !q_clear;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      resp_q <= '0;
      eq_data_q <= `ISR_ZERO16;
      eq_valid_q <= 1'b0;
      all_mode_q <= 1'b0;
    end
    else
    begin
      resp_q.valid <= is_read;
      resp_q.data <= rd_mux;
      eq_valid_q <= eq_answer;
      eq_data_q <= eq_word;
      all_mode_q <= all_next;
    end
  end

  assign resp = resp_q;
  assign eq_data = eq_data_q;
  assign eq_valid = eq_valid_q;
  assign eq_more = all_mode_q;

  ////////////////////////////////////////////////////////////////////////
  // Checks.
  property p_std_clear;
    @(posedge clk) disable iff (!nrst)
    (rd_std && (std_set == `ISR_ZERO8)) |=> (std_event_q == `ISR_ZERO8);
  endproperty
  a_std_clear: assert property (p_std_clear)
    else $error("standard event latch not cleared by query");

  property p_std_ret;
    @(posedge clk) disable iff (!nrst)
    rd_std |=> (resp.valid && resp.data[7:0] == $past(std_event_q));
  endproperty
  a_std_ret: assert property (p_std_ret)
    else $error("standard event query returned wrong value");

  property p_master;
    @(posedge clk) disable iff (!nrst)
    master_request == |(summary_byte & srq_mask_q & 8'hbf);
  endproperty
  a_master: assert property (p_master)
    else $error("master request mismatch");

  property p_op_sum;
    @(posedge clk) disable iff (!nrst)
    summary_byte[`ISR_SB_OP] == |(op_event_q & op_mask_q);
  endproperty
  a_op_sum: assert property (p_op_sum)
    else $error("operation summary mismatch");

  property p_reply;
    @(posedge clk) disable iff (!nrst)
    summary_byte[`ISR_SB_REPLY] == out_buf_nonempty;
  endproperty
  a_reply: assert property (p_reply)
    else $error("reply pending mismatch");

  property p_latch;
    @(posedge clk) disable iff (!nrst)
    (op_event_q[0] && !rd_op && !cls) |=> op_event_q[0];
  endproperty
  a_latch: assert property (p_latch)
    else $error("operation event bit dropped without clear");

  property p_summary_noclear;
    @(posedge clk) disable iff (!nrst)
    (cmd == isr_pkg::ISR_CMD_RD_SUMMARY) && std_event_q[0]
      |=> std_event_q[0];
  endproperty
  a_summary_noclear: assert property (p_summary_noclear)
    else $error("summary read cleared an event");

  property p_lost;
    @(posedge clk) disable iff (!nrst)
    reply_lost |=> std_event_q[`ISR_SE_QUERY];
  endproperty
  a_lost: assert property (p_lost)
    else $error("query fault not set on lost output");

  property p_range;
    @(posedge clk) disable iff (!nrst)
    (q_push && range_bits[`ISR_SE_RUN]) |=> std_event_q[`ISR_SE_RUN];
  endproperty
  a_range: assert property (p_range)
    else $error("run fault not set for pushed code");

  property p_pos_refused;
    @(posedge clk) disable iff (!nrst)
    (err_push && !err_code[15] && !q_pop && !q_clear) |=>
      (q_count == $past(q_count));
  endproperty
  a_pos_refused: assert property (p_pos_refused)
    else $error("positive code entered queue");

  property p_err_avail;
    @(posedge clk) disable iff (!nrst)
    err_available == (q_count != `ISR_ZERO_CW);
  endproperty
  a_err_avail: assert property (p_err_avail)
    else $error("error available mismatch");

  c_std_read: cover property (@(posedge clk) disable iff (!nrst)
    std_summary ##1 rd_std ##1 !std_summary);
  c_master: cover property (@(posedge clk) disable iff (!nrst)
    master_request);
  c_read_all: cover property (@(posedge clk) disable iff (!nrst)
    all_mode_q [*2]);
endmodule : isr_status
`default_nettype wire

// [tb/isr_host_model.sv]
`default_nettype none
// Behavioural command interpreter that talks to the status block.
module isr_host_model (
  // Clock
  input wire logic clk,
  // Requests towards the status block
  output isr_pkg::isr_req_type req,
  output isr_pkg::isr_eq_op_type eq_op,
  output logic err_push,
  output logic [15:0] err_code,
  // Answers from the status block
  input wire isr_pkg::isr_resp_type resp,
  input wire logic [15:0] eq_data,
  input wire logic eq_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] rd_data;
  logic rd_ok;

  initial
  begin
    req = '{cmd: isr_pkg::ISR_CMD_NONE, data: 16'h0000};
    eq_op = isr_pkg::ISR_EQ_NONE;
    err_push = 1'b0;
    err_code = 16'h0000;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Every request is a one-cycle pulse; the answer is sampled one edge later.
  task automatic send(input isr_pkg::isr_cmd_type c, input logic [15:0] d);
    @(posedge clk);
    req <= '{cmd: c, data: d};
    @(posedge clk);
    req <= '{cmd: isr_pkg::ISR_CMD_NONE, data: ~d};
    #1;
    rd_ok = resp.valid;
    rd_data = resp.data;
  endtask : send

  task automatic queue_op(input isr_pkg::isr_eq_op_type op);
    @(posedge clk);
    eq_op <= op;
    @(posedge clk);
    eq_op <= isr_pkg::ISR_EQ_NONE;
    #1;
    rd_ok = eq_valid;
    rd_data = eq_data;
  endtask : queue_op

  // The code lines are inverted once the strobe drops, so a stale negative code
  // turns non-negative and would be refused by the block.
  task automatic push(input logic [15:0] code);
    @(posedge clk);
    err_push <= 1'b1;
    err_code <= code;
    @(posedge clk);
    err_push <= 1'b0;
    err_code <= ~code;
  endtask : push
endmodule : isr_host_model
`default_nettype wire

// [tb/tb_instrument_status_reporting.sv]
`default_nettype none
module tb_instrument_status_reporting;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [15:0] code;
    logic [15:0] std;
  } isr_row_type;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  isr_pkg::isr_req_type req;
  isr_pkg::isr_resp_type resp;
  isr_pkg::isr_eq_op_type eq_op;
  logic [15:0] eq_data;
  logic eq_valid;
  logic eq_more;
  logic err_push;
  logic [15:0] err_code;
  logic out_buf_nonempty = 1'b0;
  logic reply_lost = 1'b0;
  logic done_cmd = 1'b0;
  logic ops_pending = 1'b0;
  logic [7:0] op_cond = 8'h00;
  logic [15:0] quest_cond = 16'h0000;
  logic [7:0] summary_byte;
  logic master_request;
  logic err_available;
  int mismatches = 0;
  int num_checks = 0;
  isr_row_type rows [9];
  isr_pkg::isr_cmd_type wr_cmd [4];
  isr_pkg::isr_cmd_type rd_cmd [4];
  logic [15:0] mask_val [4];

  always #25 clk = ~clk;

  isr_status isr_status_inst (
    .clk(clk), .nrst(nrst), .req(req), .resp(resp), .eq_op(eq_op),
    .eq_data(eq_data), .eq_valid(eq_valid), .eq_more(eq_more),
    .err_push(err_push), .err_code(err_code),
    .out_buf_nonempty(out_buf_nonempty), .reply_lost(reply_lost),
    .done_cmd(done_cmd), .ops_pending(ops_pending), .op_cond(op_cond),
    .quest_cond(quest_cond), .summary_byte(summary_byte),
    .master_request(master_request), .err_available(err_available)
  );

  isr_host_model isr_host_model_inst (
    .clk(clk), .req(req), .eq_op(eq_op), .err_push(err_push),
    .err_code(err_code), .resp(resp), .eq_data(eq_data),
    .eq_valid(eq_valid)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [15:0] seen,
                       input logic [15:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : test_done

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : wt

  task automatic rd(input isr_pkg::isr_cmd_type c, input logic [15:0] exp);
    isr_host_model_inst.send(c, 16'h0000);
    check("resp_valid", {15'h0000, isr_host_model_inst.rd_ok}, 16'h0001);
    check(c.name(), isr_host_model_inst.rd_data, exp);
  endtask : rd

  task automatic sb(input logic [7:0] exp);
    check("summary_byte", {8'h00, summary_byte}, {8'h00, exp});
    check("master", {15'h0000, master_request}, {15'h0000, exp[6]});
  endtask : sb

  // A hang must still reach the verdict rather than stall the run.
  initial
  begin
    #200us;
    mismatches++;
    test_done();
  end

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    // The positive code goes first, so a full queue cannot hide a wrong
    // acceptance of it.
    rows = '{'{16'h0005, 16'h0000}, '{16'hff9c, 16'h0020},
             '{16'hff48, 16'h0020}, '{16'hff38, 16'h0010},
             '{16'hfeda, 16'h0010}, '{16'hfed4, 16'h0008},
             '{16'hfe93, 16'h0008}, '{16'hfe70, 16'h0004},
             '{16'hfe48, 16'h0004}};
    wr_cmd = '{isr_pkg::ISR_CMD_WR_SRQ_MASK, isr_pkg::ISR_CMD_WR_STD_MASK,
               isr_pkg::ISR_CMD_WR_OP_MASK, isr_pkg::ISR_CMD_WR_QU_MASK};
    rd_cmd = '{isr_pkg::ISR_CMD_RD_SRQ_MASK, isr_pkg::ISR_CMD_RD_STD_MASK,
               isr_pkg::ISR_CMD_RD_OP_MASK, isr_pkg::ISR_CMD_RD_QU_MASK};
    mask_val = '{16'h00a8, 16'h00bd, 16'h0067, 16'h03ff};
    wt(2);
    nrst <= 1'b1;
    wt(1);
    for (int i = 0; i < 4; i++)
      rd(rd_cmd[i], 16'h0000);
    rd(isr_pkg::ISR_CMD_RD_STD_EVENT, 16'h0080);
    rd(isr_pkg::ISR_CMD_RD_STD_EVENT, 16'h0000);
    for (int i = 0; i < 9; i++)
    begin
      isr_host_model_inst.push(rows[i].code);
      rd(isr_pkg::ISR_CMD_RD_STD_EVENT, rows[i].std);
    end
    // Error queue: the positive code must not have been stored.
    isr_host_model_inst.queue_op(isr_pkg::ISR_EQ_COUNT);
    check("count", isr_host_model_inst.rd_data, 16'h0008);
    isr_host_model_inst.queue_op(isr_pkg::ISR_EQ_NEXT);
    check("next", isr_host_model_inst.rd_data, rows[1].code);
    check("err_avail", {15'h0000, err_available}, 16'h0001);
    isr_host_model_inst.queue_op(isr_pkg::ISR_EQ_ALL);
    for (int i = 2; i < 9; i++)
    begin
      if (i > 2)
        wt(1);
      check("all_valid", {15'h0000, eq_valid}, 16'h0001);
      check("all_data", eq_data, rows[i].code);
      check("all_more", {15'h0000, eq_more}, {15'h0000, i < 8});
    end
    isr_host_model_inst.queue_op(isr_pkg::ISR_EQ_CLEAR);
    isr_host_model_inst.queue_op(isr_pkg::ISR_EQ_COUNT);
    check("count_clr", isr_host_model_inst.rd_data, 16'h0000);
    check("err_avail", {15'h0000, err_available}, 16'h0000);
    // Enable masks.
    for (int i = 0; i < 4; i++)
    begin
      isr_host_model_inst.send(wr_cmd[i], mask_val[i]);
      rd(rd_cmd[i], mask_val[i]);
    end
    sb(8'h00);
    @(posedge clk);
    reply_lost <= 1'b1;
    @(posedge clk);
    reply_lost <= 1'b0;
    wt(1);
    sb(8'h60);
    rd(isr_pkg::ISR_CMD_RD_SUMMARY, 16'h0060);
    sb(8'h60);
    isr_host_model_inst.send(isr_pkg::ISR_CMD_WR_SRQ_MASK, 16'h0088);
    sb(8'h20);
    isr_host_model_inst.send(isr_pkg::ISR_CMD_WR_SRQ_MASK, 16'h00a8);
    rd(isr_pkg::ISR_CMD_RD_STD_EVENT, 16'h0004);
    sb(8'h00);
    @(posedge clk);
    out_buf_nonempty <= 1'b1;
    wt(1);
    sb(8'h10);
    @(posedge clk);
    out_buf_nonempty <= 1'b0;
    wt(1);
    sb(8'h00);
    // Unused operation bits must stay out of both views.
    @(posedge clk);
    op_cond <= 8'hff;
    wt(2);
    sb(8'hc0);
    rd(isr_pkg::ISR_CMD_RD_OP_COND, 16'h0067);
    @(posedge clk);
    op_cond <= 8'h00;
    wt(1);
    rd(isr_pkg::ISR_CMD_RD_OP_COND, 16'h0000);
    rd(isr_pkg::ISR_CMD_RD_OP_EVENT, 16'h0067);
    sb(8'h00);
    @(posedge clk);
    quest_cond <= 16'hffff;
    wt(2);
    sb(8'h48);
    rd(isr_pkg::ISR_CMD_RD_QU_COND, 16'h03ff);
    isr_host_model_inst.send(isr_pkg::ISR_CMD_CLEAR_STATUS, 16'h0000);
    wt(1);
    sb(8'h00);
    rd(isr_pkg::ISR_CMD_RD_QU_EVENT, 16'h0000);
    @(posedge clk);
    quest_cond <= 16'h0000;
    ops_pending <= 1'b1;
    done_cmd <= 1'b1;
    @(posedge clk);
    done_cmd <= 1'b0;
    wt(2);
    sb(8'h00);
    @(posedge clk);
    ops_pending <= 1'b0;
    wt(2);
    sb(8'h60);
    rd(isr_pkg::ISR_CMD_RD_STD_EVENT, 16'h0001);
    // A second reset mid-run must drop the service request mask written above and raise power-up again.
    @(posedge clk);
    nrst <= 1'b0;
    wt(2);
    nrst <= 1'b1;
    wt(1);
    rd(isr_pkg::ISR_CMD_RD_SRQ_MASK, 16'h0000);
    rd(isr_pkg::ISR_CMD_RD_STD_EVENT, 16'h0080);
    test_done();
  end
endmodule : tb_instrument_status_reporting
`default_nettype wire
